// File: verification/dual_mode_wiper_serial_port_test.sv
// Purpose: Two chained ports driven by a host model in both modes
// Assumes: Mode strap only changes under reset
// Notes: Second port sits on the chain node and has the other address
`timescale 1ns/1ps
module dual_mode_wiper_serial_port_test
  import wss_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic mode = 1'b0;
  logic strap = 1'b1;
  logic h_clk, h_cs_n, h_data, oe, oe2, c_oe, pd, pd2;
  logic [7:0] wip, wip2, tap, tap2;
  logic [8:0] r;
  int mismatches = 0;
  int n_compared = 0;
  // Wired-and data line with pull-up; chain node pulled up
  wire logic sda = h_data & ~oe & ~oe2;
  wire logic cs1 = mode ? strap : h_cs_n;
  wire logic cs2 = mode ? ~strap : h_cs_n;
  wire logic si2 = mode ? sda : ~c_oe;
  always #5 i_clk = ~i_clk;
  wss_host_model host (.i_sda(sda), .o_clk(h_clk), .o_cs_n(h_cs_n), .o_data(h_data));
  wss_port_top DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(h_clk), .i_cs_n_address_strap_pin(cs1),
    .i_serial_in_pin(sda), .i_interface_select_strap(mode), .o_sda_out(), .o_sda_oe(oe), .o_chain_out_pin(),
    .o_chain_out_oe(c_oe), .o_wiper_register(wip), .o_power_down(pd), .o_tap_code(tap));
  wss_port_top far (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(h_clk), .i_cs_n_address_strap_pin(cs2),
    .i_serial_in_pin(si2), .i_interface_select_strap(mode), .o_sda_out(), .o_sda_oe(oe2), .o_chain_out_pin(),
    .o_chain_out_oe(), .o_wiper_register(wip2), .o_power_down(pd2), .o_tap_code(tap2));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic m);
    @(negedge i_clk) i_reset_n = 1'b0;
    mode = m;
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (10) @(negedge i_clk);
  endtask : do_reset
  // Addressed write of n data bytes; nak is the expected address answer
  task automatic wr(input logic [7:0] a, input logic [7:0] ins, input logic [15:0] d, input int n, input logic nak);
    host.start();
    host.byte9({a, 1'b1}, r);
    check({7'h00, r[0]}, {7'h00, nak});
    if (!r[0]) begin
      host.byte9({ins, 1'b1}, r);
      check({7'h00, r[0]}, 8'h00);
      for (int i = n - 1; i >= 0; i--) begin
        host.byte9({d[i*8 +: 8], 1'b1}, r);
        check({7'h00, r[0]}, 8'h00);
      end
    end
    host.stop();
    repeat (10) @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] want);
    host.start();
    host.byte9(9'h0B7, r);
    check({7'h00, r[0]}, 8'h00);
    // Controller acknowledges the first byte, so the wiper is sent again
    host.byte9(9'h1FE, r);
    check(r[8:1], want);
    host.byte9(9'h1FF, r);
    check(r[8:1], want);
    host.stop();
  endtask : rd
  initial begin
    do_reset(1'b0);
    check(wip, WSS_MIDSCALE);
    check(tap, 8'h80);
    host.spi(24'h0000A5, 8);
    check(wip, 8'hA5);
    host.spi(24'h0005C3, 11);
    check(wip, 8'hC3);
    host.spi(24'hF5AC3C, 20);
    check(wip, 8'h3C);
    check(wip2, 8'hAC);
    do_reset(1'b1);
    wr(8'h5A, 8'h00, 16'h0037, 1, 1'b0);
    check(wip, 8'h37);
    rd(8'h37);
    wr(8'h7A, 8'h00, 16'h0099, 1, 1'b1);
    check(wip, 8'h37);
    wr(8'h58, 8'h00, 16'h0066, 1, 1'b0);
    check(wip2, 8'h66);
    check(tap2, 8'h66);
    check({7'h00, pd2}, 8'h00);
    check(wip, 8'h37);
    wr(8'h5A, 8'h20, 16'h1122, 2, 1'b0);
    check({7'h00, pd}, 8'h01);
    check(tap, 8'h00);
    check(wip, 8'h22);
    rd(8'h22);
    wr(8'h5A, 8'h00, 16'h0044, 1, 1'b0);
    check(tap, 8'h44);
    wr(8'h5A, 8'hDF, 16'h0000, 0, 1'b0);
    check(wip, 8'h80);
    check({7'h00, pd}, 8'h00);
    give_verdict();
  end
  // Whole run needs about 47 us of bus time
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule : dual_mode_wiper_serial_port_test
bind wss_port_top wss_port_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk),
  .i_cs_n_address_strap_pin(i_cs_n_address_strap_pin), .i_serial_in_pin(i_serial_in_pin),
  .i_interface_select_strap(i_interface_select_strap), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_chain_out_pin(o_chain_out_pin), .o_chain_out_oe(o_chain_out_oe), .o_wiper_register(o_wiper_register),
  .o_power_down(o_power_down), .o_tap_code(o_tap_code));

// File: verification/wss_host_model.sv
// Purpose: Host model driving serial clock, select and data pins
// Assumes: Data line is pulled up and devices only pull it low
// Notes: After a frame data shows the inverse of its last bit
`timescale 1ns/1ps
module wss_host_model (
  input wire logic i_sda,
  output logic o_clk,
  output logic o_cs_n,
  output logic o_data
);
  localparam int H = 100;
  initial begin
    o_clk = 1'b0;
    o_cs_n = 1'b1;
    o_data = 1'b1;
  end
  task automatic pulse(input int p);
    #p o_clk = 1'b1;
    #p o_clk = 1'b0;
  endtask : pulse
  // Shift frame MSB first; two idle pulses first let the mode settle
  task automatic spi(input logic [23:0] w, input int n);
    repeat (2) pulse(6);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_data = w[i];
      // Chained frames get a longer low phase so the pulled-up chain node can settle
      if (n > 8) #6;
      pulse(6);
    end
    #6 o_cs_n = 1'b1;
    o_data = ~o_data;
    #100;
  endtask : spi
  task automatic start();
    o_data = 1'b1;
    #H o_clk = 1'b1;
    #H o_data = 1'b0;
    #H o_clk = 1'b0;
  endtask : start
  task automatic stop();
    o_data = 1'b0;
    #H o_clk = 1'b1;
    #H o_data = 1'b1;
    #H;
  endtask : stop
  // Eight bits plus ninth clock; a 1 releases the line
  task automatic byte9(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      o_data = d[i];
      #H o_clk = 1'b1;
      #H r[i] = i_sda;
      o_clk = 1'b0;
    end
  endtask : byte9
endmodule : wss_host_model

// File: verification/wss_port_chk.sv
// Purpose: Port-level timing checks for the wiper serial port
// Assumes: Link pins are sampled on i_clk as plain data
// Notes: Chip-select age saturates so long idle spans never wrap
`timescale 1ns/1ps
module wss_port_chk
  import wss_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_cs_n_address_strap_pin,
  input wire logic i_serial_in_pin,
  input wire logic i_interface_select_strap,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_chain_out_pin,
  input wire logic o_chain_out_oe,
  input wire logic [7:0] o_wiper_register,
  input wire logic o_power_down,
  input wire logic [7:0] o_tap_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic cs_q;
  logic [2:0] cs_age;
  // Cycles since chip select was last seen rising
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_q <= 1'b1;
      cs_age <= 3'h7;
    end else begin
      cs_q <= i_cs_n_address_strap_pin;
      cs_age <= (i_cs_n_address_strap_pin && !cs_q) ? 3'h0 : ((cs_age == 3'h7) ? cs_age : cs_age + 3'h1);
    end
  end
  sequence s_pd_held;
    o_power_down [*2];
  endsequence
  sequence s_on_steady;
    (!o_power_down && $stable(o_wiper_register)) [*3];
  endsequence
  property p_pd_ground;
    s_pd_held |-> o_tap_code == 8'h00;
  endproperty
  a_pd_ground: assert property (p_pd_ground) else $error("tap not grounded");
  property p_tap_follow;
    s_on_steady |-> o_tap_code == o_wiper_register;
  endproperty
  a_tap_follow: assert property (p_tap_follow) else $error("tap differs from wiper");
  property p_reset_mid;
    $rose(i_reset_n) |-> o_wiper_register == WSS_MIDSCALE && o_tap_code == 8'h80 && !o_power_down;
  endproperty
  a_reset_mid: assert property (p_reset_mid) else $error("bad reset value");
  property p_sda_quiet;
    !i_interface_select_strap [*4] |-> !o_sda_oe;
  endproperty
  a_sda_quiet: assert property (p_sda_quiet) else $error("data pulled in shift mode");
  property p_chain_quiet;
    i_interface_select_strap [*4] |-> !o_chain_out_oe;
  endproperty
  a_chain_quiet: assert property (p_chain_quiet) else $error("chain pulled in target mode");
  property p_sda_scl;
    $changed(o_sda_oe) |-> !i_link_clk;
  endproperty
  a_sda_scl: assert property (p_sda_scl) else $error("data moved with clock high");
  property p_pins_od;
    o_sda_out == 1'b0 && o_chain_out_pin == 1'b0;
  endproperty
  a_pins_od: assert property (p_pins_od) else $error("open-drain value not low");
  property p_pd_mode;
    !i_interface_select_strap |-> $stable(o_power_down);
  endproperty
  a_pd_mode: assert property (p_pd_mode) else $error("power-down moved in shift mode");
  property p_latch_time;
    $changed(o_wiper_register) && !i_interface_select_strap |-> cs_age inside {[2:6]};
  endproperty
  a_latch_time: assert property (p_latch_time) else $error("wiper moved without select rise");
endmodule : wss_port_chk

// File: verilog/wss_pkg.sv
// Purpose: Shared constants, types and helpers for the dual-mode wiper serial port
// Assumes: 8-bit wiper register, one serial clock pin shared by both modes
// Notes: All numbers used by more than one file live here
// How it works
// - Strap low selects 3-wire shift mode; strap high selects two-wire target mode.
// - While chip select is low, each rising serial clock shifts one input bit.
// - Rising chip select copies the 8-bit shift register into the wiper register.
// - Extra bits in one frame push out the earliest ones; last eight remain.
// - Chain output is open-drain and carries bits shifted out toward the next device.
// - Beyond 16 bits the leading bits fall out; each device keeps its last eight.
// - Target address is six fixed upper bits followed by the address strap level.
// - On address match pull the data line low on the ninth clock; else ignore.
// - Direction bit high means read from the device, low means write.
// - Write instruction byte: bit 6 midscale reset, bit 5 power-down, others ignored.
// - Midscale reset bit overwrites the wiper register with the midscale code.
// - Power-down opens top terminal, shorts wiper to bottom, keeps the wiper register.
// - Writes are accepted while powered down; stored value returns when it clears.
// - After the instruction ack, a data byte is taken and loaded as its ack begins.
// - Data line changes only while the serial clock is low, except START and STOP.
// - START is data falling with clock high; STOP is data rising with clock high.
// - A read drives the wiper value right after the address ack.
// - Further data bytes in one write reuse the instruction; reads may repeat.
// - The midscale code is hexadecimal 80.
// - The wiper register presets to midscale at reset.
package wss_pkg;

  localparam logic [7:0] WSS_MIDSCALE = 8'h80;
  localparam logic [7:0] WSS_WIPER_RESET = WSS_MIDSCALE;
  localparam logic [5:0] WSS_ADDR_UPPER = 6'h16;
  localparam logic [3:0] WSS_BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] WSS_SHIFT_RESET = 8'h00;
  localparam int WSS_MSB_POS = 7;
  localparam int WSS_DIR_POS = 0;

  // Instruction byte layout, most significant bit first
  typedef struct packed {
    logic ignored_top;
    logic midscale_reset_bit;
    logic power_down_bit;
    logic [4:0] ignored_low;
  } wss_instr_t;

  typedef enum {
    WSS_IDLE,
    WSS_ADDR,
    WSS_ADDR_ACK,
    WSS_INSTR,
    WSS_INSTR_ACK,
    WSS_WDATA,
    WSS_DATA_ACK,
    WSS_RDATA,
    WSS_RD_ACK
  } wss_state_t;

  // Shift one new bit into the low end; the top bit falls out
  function automatic logic [7:0] wss_shift_in(input logic [7:0] word, input logic bit_in);
    wss_shift_in = {word[6:0], bit_in};
  endfunction : wss_shift_in

endpackage : wss_pkg

// File: verilog/wss_port_top.sv
// Purpose: Serial control port of a 256-step wiper, 3-wire shift or two-wire target
// Assumes: i_clk much faster than the serial clock; pins sampled through two flops
// Notes: Chain output runs on the serial clock itself so chained parts see it in time
`timescale 1ns/1ps
module wss_port_top
  import wss_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_cs_n_address_strap_pin,
  input wire logic i_serial_in_pin,
  input wire logic i_interface_select_strap,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_chain_out_pin,
  output logic o_chain_out_oe,
  output logic [7:0] o_wiper_register,
  output logic o_power_down,
  output logic [7:0] o_tap_code
);

  // Synchronised pins: clock, data, select/address strap, interface strap
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic cs_s;
  logic dis_s;
  logic scl_d;
  logic sda_d;
  logic cs_d;

  logic [7:0] spi_word;
  logic chain_oe_link;

  wss_state_t state;
  wss_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic sda_oe;
  logic next_sda_oe;
  logic [7:0] wiper;
  logic [7:0] next_wiper;
  logic pd;
  logic next_pd;

  wire mode_i2c;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire cs_rise;
  wire byte_done;
  wire addr_match;
  wire dir_read;
  wss_instr_t instr;

  wss_sync2 #(.WIDTH(4), .RESET_VALUE(4'hF)) u_pin_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_link_clk, i_serial_in_pin, i_cs_n_address_strap_pin, i_interface_select_strap}),
    .o_sync(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign dis_s = pins_s[0];

  // Shift register lives on the serial clock so the chain keeps pace
  wss_shift_link u_shift (
    .i_link_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_chip_select_n(i_cs_n_address_strap_pin),
    .i_serial_in_pin(i_serial_in_pin),
    .i_interface_select_strap(i_interface_select_strap),
    .o_shift_word(spi_word),
    .o_chain_out_oe(chain_oe_link)
  );

  // Delayed copies for edge detection, taken from the second stage only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      cs_d <= cs_s;
    end
  end

  // Bus event decode
  assign mode_i2c = dis_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
  assign cs_rise = cs_s && !cs_d;
  assign byte_done = (cnt == WSS_BITS_PER_BYTE);
  assign addr_match = (rx[7:1] == {WSS_ADDR_UPPER, cs_s});
  assign dir_read = rx[WSS_DIR_POS];
  assign instr = wss_instr_t'(rx);

  // Next-state logic for the two-wire target and the wiper register
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rx = rx;
    next_tx = tx;
    next_sda_oe = sda_oe;
    next_wiper = wiper;
    next_pd = pd;
    if (!mode_i2c) begin
      // Target stays idle and released in shift mode
      next_state = WSS_IDLE;
      next_sda_oe = 1'b0;
      // Word is still because shifting stops while chip select is high
      if (cs_rise) begin
        next_wiper = spi_word;
      end
    end else if (start_seen) begin
      // A START also serves as a repeated start mid-transfer
      next_state = WSS_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_state = WSS_IDLE;
      next_sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Sample data while the clock is high
      case (state)
        WSS_ADDR, WSS_INSTR, WSS_WDATA: begin
          next_rx = wss_shift_in(rx, sda_s);
          next_cnt = cnt + 4'h1;
        end
        WSS_RDATA: begin
          next_cnt = cnt + 4'h1;
        end
        WSS_RD_ACK: begin
          // Not-acknowledge: stop driving and wait for STOP
          if (sda_s) begin
            next_state = WSS_IDLE;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (scl_fall) begin
      // Change the data line only while the clock is low
      case (state)
        WSS_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              next_state = WSS_ADDR_ACK;
              next_sda_oe = 1'b1;
            end else begin
              next_state = WSS_IDLE;
            end
          end
        end
        WSS_ADDR_ACK: begin
          next_cnt = 4'h0;
          if (dir_read) begin
            next_state = WSS_RDATA;
            next_tx = wiper;
            next_sda_oe = !wiper[WSS_MSB_POS];
          end else begin
            next_state = WSS_INSTR;
            next_sda_oe = 1'b0;
          end
        end
        WSS_INSTR: begin
          if (byte_done) begin
            next_pd = instr.power_down_bit;
            if (instr.midscale_reset_bit) begin
              next_wiper = WSS_MIDSCALE;
            end
            next_state = WSS_INSTR_ACK;
            next_sda_oe = 1'b1;
          end
        end
        WSS_INSTR_ACK, WSS_DATA_ACK: begin
          // Further data bytes reuse the instruction already taken
          next_state = WSS_WDATA;
          next_cnt = 4'h0;
          next_sda_oe = 1'b0;
        end
        WSS_WDATA: begin
          if (byte_done) begin
            next_wiper = rx;
            next_state = WSS_DATA_ACK;
            next_sda_oe = 1'b1;
          end
        end
        WSS_RDATA: begin
          if (byte_done) begin
            next_state = WSS_RD_ACK;
            next_sda_oe = 1'b0;
          end else begin
            next_tx = {tx[6:0], 1'b0};
            next_sda_oe = !tx[6];
          end
        end
        WSS_RD_ACK: begin
          // Controller acknowledged, so send the wiper again
          next_state = WSS_RDATA;
          next_cnt = 4'h0;
          next_tx = wiper;
          next_sda_oe = !wiper[WSS_MSB_POS];
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // Target state registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= WSS_IDLE;
      cnt <= 4'h0;
      rx <= WSS_SHIFT_RESET;
      tx <= WSS_SHIFT_RESET;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rx <= next_rx;
      tx <= next_tx;
      sda_oe <= next_sda_oe;
    end
  end

  // Wiper register presets to midscale; power-down flag clears at reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wiper <= WSS_WIPER_RESET;
      pd <= 1'b0;
    end else begin
      wiper <= next_wiper;
      pd <= next_pd;
    end
  end

  // Registered outputs; tap code drops to the bottom terminal while powered down
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wiper_register <= WSS_WIPER_RESET;
      o_power_down <= 1'b0;
      o_tap_code <= WSS_WIPER_RESET;
    end else begin
      o_wiper_register <= wiper;
      o_power_down <= pd;
      o_tap_code <= pd ? 8'h00 : wiper;
    end
  end

  // Open-drain data line only ever drives low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe;

  // Chain pin comes from the serial-clock flop so the next part samples it on the next edge
  assign o_chain_out_pin = 1'b0;
  assign o_chain_out_oe = chain_oe_link;

endmodule : wss_port_top

// File: verilog/wss_shift_link.sv
// Purpose: 3-wire shift register and open-drain chain output on the serial clock
// Assumes: Serial clock also pulses outside frames so the strap settles; data and select are launched by the controller
// Notes: The word is handed over by holding it still while chip select is high
`timescale 1ns/1ps
module wss_shift_link
  import wss_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  input wire logic i_chip_select_n,
  input wire logic i_serial_in_pin,
  input wire logic i_interface_select_strap,
  output logic [7:0] o_shift_word,
  output logic o_chain_out_oe
);

  logic strap_link;
  logic shift_en;
  logic [7:0] next_shift;

  // Strap is a static pin; resets to two-wire so the chain stays released
  wss_sync2 #(.WIDTH(1), .RESET_VALUE(1'b1)) u_strap_sync (
    .i_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_interface_select_strap),
    .o_sync(strap_link)
  );

  assign shift_en = !strap_link && !i_chip_select_n;
  assign next_shift = shift_en ? wss_shift_in(o_shift_word, i_serial_in_pin) : o_shift_word;

  // Shift on rising edges while selected; oldest bit leaves at the top
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_shift_word <= WSS_SHIFT_RESET;
      o_chain_out_oe <= 1'b0;
    end else begin
      o_shift_word <= next_shift;
      // Pull low for a zero only; released in two-wire mode
      o_chain_out_oe <= !strap_link && !next_shift[WSS_MSB_POS];
    end
  end

endmodule : wss_shift_link

// File: verilog/wss_sync2.sv
// Purpose: Two-flop synchroniser for a group of slow levels
// Assumes: Each bit is an independent level
// Notes: Only the second stage may be read outside this module
`timescale 1ns/1ps
module wss_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1 <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : wss_sync2
